/* File: hw/rro_pkg.sv */
// package of constants and carrier types for the rotate and return unit
package rro_pkg;
    localparam int unsigned RRO_DATA_W = 8;
    localparam int unsigned RRO_PC_W   = 12;
    localparam int unsigned RRO_MSB    = 7;
    localparam int unsigned RRO_LSB    = 0;
    localparam logic [7:0]  RRO_ACC_RST = 8'h00;
    localparam logic [11:0] RRO_PC_RST  = 12'h000;
    localparam logic        RRO_C_RST   = 1'b0;
    localparam logic        RRO_GIE_RST = 1'b0;

    // operation codes presented on the request port
    typedef enum logic [3:0] {
        RRO_NOP              = 4'h0,
        RRO_ROT_LEFT_MEM     = 4'h1,
        RRO_ROT_LEFT_ACC     = 4'h2,
        RRO_ROT_LEFT_VC_MEM  = 4'h3,
        RRO_ROT_LEFT_VC_ACC  = 4'h4,
        RRO_ROT_RIGHT_MEM    = 4'h5,
        RRO_ROT_RIGHT_ACC    = 4'h6,
        RRO_ROT_RIGHT_VC_MEM = 4'h7,
        RRO_ROT_RIGHT_VC_ACC = 4'h8,
        RRO_SUB_EXIT         = 4'h9,
        RRO_SUB_EXIT_IMM     = 4'hA,
        RRO_INT_EXIT         = 4'hB
    } rro_op_e;

    // one request: operation, memory operand, immediate and stack top
    typedef struct packed {
        rro_op_e       op;
        logic [7:0]    operand;
        logic [7:0]    imm;
        logic [11:0]   stack_top;
    } rro_req_s;

    // memory write-back command
    typedef struct packed {
        logic          we;
        logic [7:0]    data;
    } rro_mem_s;
endpackage

/* File: hw/rro_core.sv */
// rotate and return execution unit with accumulator, carry, pc, gie
//
// What this block does
// - memory rotate-left-via-carry: carry takes bit 7
// - old carry enters memory bit 0
// - acc rotate-left-via-carry: result to accumulator
// - acc rotate-left-via-carry leaves memory unwritten
// - memory rotate right, bit 0 wraps to 7
// - acc rotate right, memory stays unchanged
// - memory rotate-right-via-carry as 9-bit loop
// - acc rotate-right-via-carry, carry gets bit 0
// - acc rotate-right-via-carry leaves memory unwritten
module rro_core
    import rro_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             en,
    input  wire logic             req_valid,
    input  wire rro_req_s         req,
    output rro_mem_s              mem_wr,
    output logic [7:0]            acc,
    output logic                  carry,
    output logic [11:0]           pc,
    output logic                  pc_load,
    output logic                  global_interrupt_enable
);
    logic [7:0]  acc_q,  acc_d;
    logic        c_q,    c_d;
    logic [11:0] pc_q,   pc_d;
    logic        gie_q,  gie_d;
    logic        pcl_q,  pcl_d;
    rro_mem_s    mw_q,   mw_d;
    logic [7:0]  m;

    // next-state datapath for one accepted request
    always_comb begin
        m     = req.operand;
        acc_d = acc_q;
        c_d   = c_q;
        pc_d  = pc_q;
        gie_d = gie_q;
        pcl_d = 1'b0;
        mw_d  = '{we: 1'b0, data: mw_q.data};
        if (req_valid) begin
            unique case (req.op)
                RRO_ROT_LEFT_MEM: begin
                    mw_d = '{we: 1'b1, data: {m[6:0], m[RRO_MSB]}};
                end
                RRO_ROT_LEFT_ACC: begin
                    acc_d = {m[6:0], m[RRO_MSB]};
                end
                RRO_ROT_LEFT_VC_MEM: begin
                    mw_d = '{we: 1'b1, data: {m[6:0], c_q}};
                    c_d  = m[RRO_MSB];
                end
                RRO_ROT_LEFT_VC_ACC: begin
                    acc_d = {m[6:0], c_q};
                    c_d   = m[RRO_MSB];
                end // no memory write
                RRO_ROT_RIGHT_MEM: begin
                    mw_d = '{we: 1'b1, data: {m[RRO_LSB], m[7:1]}};
                end
                RRO_ROT_RIGHT_ACC: begin
                    acc_d = {m[RRO_LSB], m[7:1]};
                end
                RRO_ROT_RIGHT_VC_MEM: begin
                    mw_d = '{we: 1'b1, data: {c_q, m[7:1]}};
                    c_d  = m[RRO_LSB];
                end
                RRO_ROT_RIGHT_VC_ACC: begin
                    acc_d = {c_q, m[7:1]};
                    c_d   = m[RRO_LSB];
                end // no memory write
                RRO_SUB_EXIT: begin
                    pc_d  = req.stack_top;
                    pcl_d = 1'b1;
                end
                RRO_SUB_EXIT_IMM: begin
                    pc_d  = req.stack_top;
                    acc_d = req.imm;
                    pcl_d = 1'b1;
                end
                RRO_INT_EXIT: begin
                    pc_d  = req.stack_top;
                    gie_d = 1'b1;
                    pcl_d = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // state registers, frozen while en is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= RRO_ACC_RST;
            c_q   <= RRO_C_RST;
            pc_q  <= RRO_PC_RST;
            gie_q <= RRO_GIE_RST;
            pcl_q <= 1'b0;
            mw_q  <= '0;
        end else if (en) begin
            acc_q <= acc_d;
            c_q   <= c_d;
            pc_q  <= pc_d;
            gie_q <= gie_d;
            pcl_q <= pcl_d;
            mw_q  <= mw_d;
        end
    end

    // outputs straight from flip-flops
    assign acc                     = acc_q;
    assign carry                   = c_q;
    assign pc                      = pc_q;
    assign pc_load                 = pcl_q;
    assign global_interrupt_enable = gie_q;
    assign mem_wr                  = mw_q;

    // checks on the datapath
    property p_lvc_mem;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_LEFT_VC_MEM) |=>
            (c_q == $past(req.operand[7]) && mw_q.we &&
             mw_q.data == {$past(req.operand[6:0]), $past(c_q)});
    endproperty
    a_lvc_mem: assert property (p_lvc_mem)
        else $error("left via carry to memory wrong");

    property p_lvc_bit0;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_LEFT_VC_MEM) |=>
            mw_q.data[0] == $past(c_q);
    endproperty
    a_lvc_bit0: assert property (p_lvc_bit0)
        else $error("old carry not in bit 0");

    property p_lvc_acc;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_LEFT_VC_ACC) |=>
            (acc_q == {$past(req.operand[6:0]), $past(c_q)} &&
             c_q == $past(req.operand[7]));
    endproperty
    a_lvc_acc: assert property (p_lvc_acc)
        else $error("left via carry to acc wrong");

    property p_lvc_keep;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_LEFT_VC_ACC) |=> !mw_q.we;
    endproperty
    a_lvc_keep: assert property (p_lvc_keep)
        else $error("memory written by acc rotate");

    property p_rot_r_mem;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_RIGHT_MEM) |=>
            (mw_q.we && mw_q.data == {$past(req.operand[0]),
                                      $past(req.operand[7:1])});
    endproperty
    a_rot_r_mem: assert property (p_rot_r_mem)
        else $error("right rotate to memory wrong");

    property p_rot_r_acc;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_RIGHT_ACC) |=>
            (!mw_q.we && acc_q == {$past(req.operand[0]),
                                   $past(req.operand[7:1])});
    endproperty
    a_rot_r_acc: assert property (p_rot_r_acc)
        else $error("right rotate to acc wrong");

    property p_rvc_mem;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_RIGHT_VC_MEM) |=>
            (c_q == $past(req.operand[0]) && mw_q.we &&
             mw_q.data == {$past(c_q), $past(req.operand[7:1])});
    endproperty
    a_rvc_mem: assert property (p_rvc_mem)
        else $error("right via carry to memory wrong");

    property p_rvc_acc;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_RIGHT_VC_ACC) |=>
            (acc_q == {$past(c_q), $past(req.operand[7:1])} &&
             c_q == $past(req.operand[0]));
    endproperty
    a_rvc_acc: assert property (p_rvc_acc)
        else $error("right via carry to acc wrong");

    property p_rvc_keep;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_ROT_RIGHT_VC_ACC) |=> !mw_q.we;
    endproperty
    a_rvc_keep: assert property (p_rvc_keep)
        else $error("memory written by acc rotate");

    property p_exit_imm;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_SUB_EXIT_IMM) |=>
            (pc_q == $past(req.stack_top) && acc_q == $past(req.imm)
             && pcl_q);
    endproperty
    a_exit_imm: assert property (p_exit_imm)
        else $error("exit with immediate wrong");

    property p_exit_int;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_INT_EXIT) |=>
            (pc_q == $past(req.stack_top) && gie_q && pcl_q);
    endproperty
    a_exit_int: assert property (p_exit_int)
        else $error("interrupt exit wrong");

    // plain exit reloads pc and leaves the accumulator alone
    property p_exit_sub;
        @(posedge clk) disable iff (!resetn)
        (en && req_valid && req.op == RRO_SUB_EXIT) |=>
            (pc_q == $past(req.stack_top) && acc_q == $past(acc_q)
             && pcl_q);
    endproperty
    a_exit_sub: assert property (p_exit_sub)
        else $error("plain exit wrong");

    // once set, the interrupt enable only falls through reset
    property p_gie_hold;
        @(posedge clk) disable iff (!resetn)
        gie_q |=> gie_q;
    endproperty
    a_gie_hold: assert property (p_gie_hold)
        else $error("interrupt enable dropped");

    // write strobe only after a taken rotate with memory destination
    property p_we_cause;
        @(posedge clk) disable iff (!resetn)
        (en && !(req_valid &&
                 (req.op == RRO_ROT_LEFT_MEM ||
                  req.op == RRO_ROT_LEFT_VC_MEM ||
                  req.op == RRO_ROT_RIGHT_MEM ||
                  req.op == RRO_ROT_RIGHT_VC_MEM))) |=> !mw_q.we;
    endproperty
    a_we_cause: assert property (p_we_cause)
        else $error("memory written without memory rotate");
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the rotate and return unit
module tb
    import rro_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk       = 1'h0;
    logic        resetn    = 1'h0;
    logic        en        = 1'h0;
    logic        req_valid = 1'h0;
    rro_req_s    req       = '0;
    rro_mem_s    mem_wr;
    logic [7:0]  acc;
    logic        carry;
    logic [11:0] pc;
    logic        pc_load;
    logic        gie;
    logic        took;
    logic [31:0] exp_q[$];
    int          err_count       = 0;
    int          samples_checked = 0;
    logic        m_we, m_c, m_pl, m_g;
    logic [7:0]  m_d, m_a;
    logic [11:0] m_pc;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    rro_core dut (
        .clk                     (clk),
        .resetn                  (resetn),
        .en                      (en),
        .req_valid               (req_valid),
        .req                     (req),
        .mem_wr                  (mem_wr),
        .acc                     (acc),
        .carry                   (carry),
        .pc                      (pc),
        .pc_load                 (pc_load),
        .global_interrupt_enable (gie)
    );

    task automatic check(string name, logic [11:0] e, logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", name, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // expected outputs packed as we, data, acc, carry, pc, pc_load, gie
    function automatic logic [31:0] pack();
        return {m_we, m_d, m_a, m_c, m_pc, m_pl, m_g};
    endfunction

    task automatic check_all(logic [31:0] n);
        check("mem_we", 12'(n[31]), 12'(mem_wr.we));
        check("mem_data", 12'(n[30:23]), 12'(mem_wr.data));
        check("acc", 12'(n[22:15]), 12'(acc));
        check("carry", 12'(n[14]), 12'(carry));
        check("pc", n[13:2], pc);
        check("pc_load", 12'(n[1]), 12'(pc_load));
        check("gie", 12'(n[0]), 12'(gie));
    endtask

    task automatic model_reset();
        m_we = 1'h0; m_d = 8'h00; m_a = RRO_ACC_RST; m_c = RRO_C_RST;
        m_pc = RRO_PC_RST; m_pl = 1'h0; m_g = RRO_GIE_RST;
    endtask

    // reference behaviour of one taken request; unused codes act as nop
    task automatic model(rro_req_s r);
        logic [7:0] o;
        o = r.operand;
        m_we = 1'h0;
        m_pl = 1'h0;
        case (r.op)
            RRO_ROT_LEFT_MEM:     begin m_we = 1'h1; m_d = {o[6:0], o[7]}; end
            RRO_ROT_LEFT_ACC:     m_a = {o[6:0], o[7]};
            RRO_ROT_LEFT_VC_MEM:  begin m_we = 1'h1; m_d = {o[6:0], m_c}; m_c = o[7]; end
            RRO_ROT_LEFT_VC_ACC:  begin m_a = {o[6:0], m_c}; m_c = o[7]; end
            RRO_ROT_RIGHT_MEM:    begin m_we = 1'h1; m_d = {o[0], o[7:1]}; end
            RRO_ROT_RIGHT_ACC:    m_a = {o[0], o[7:1]};
            RRO_ROT_RIGHT_VC_MEM: begin m_we = 1'h1; m_d = {m_c, o[7:1]}; m_c = o[0]; end
            RRO_ROT_RIGHT_VC_ACC: begin m_a = {m_c, o[7:1]}; m_c = o[0]; end
            RRO_SUB_EXIT:         begin m_pc = r.stack_top; m_pl = 1'h1; end
            RRO_SUB_EXIT_IMM:     begin m_pc = r.stack_top; m_a = r.imm; m_pl = 1'h1; end
            RRO_INT_EXIT:         begin m_pc = r.stack_top; m_g = 1'h1; m_pl = 1'h1; end
            default:              ;
        endcase
    endtask

    // random request, sometimes stalled by en or not valid
    task automatic drive_one();
        rro_req_s r;
        logic     e, v;
        r.op        = rro_op_e'(4'($urandom_range(0, 15)));
        r.operand   = 8'($urandom);
        r.imm       = 8'($urandom);
        r.stack_top = 12'($urandom);
        e           = ($urandom_range(0, 7) != 0);
        v           = ($urandom_range(0, 3) != 0);
        @(posedge clk);
        req       <= r;
        en        <= e;
        req_valid <= v;
        if (e && v) begin
            model(r);
            exp_q.push_back(pack());
        end
    endtask

    // marks the edges at which a request was taken
    always @(posedge clk or negedge resetn) begin
        if (!resetn) took <= 1'h0;
        else took <= en && req_valid;
    end

    // compares each result at the falling edge, half a cycle after its taking edge
    always @(negedge clk) begin
        if (took) begin
            if (exp_q.size() == 0) check("note_present", 12'h001, 12'h000);
            else check_all(exp_q.pop_front());
        end
    end

    // two runs, the second after a reset once traffic has stopped
    initial begin
        void'($urandom(32'hE23D));
        for (int pass = 0; pass < 2; pass++) begin
            repeat (3) @(posedge clk);
            @(negedge clk);
            model_reset();
            check_all(pack());
            @(posedge clk);
            resetn <= 1'h1;
            repeat (1500) drive_one();
            @(posedge clk);
            en        <= 1'h0;
            req_valid <= 1'h0;
            repeat (3) @(posedge clk);
            check("notes_left", 12'h000, 12'(exp_q.size()));
            resetn <= 1'h0;
        end
        wrap_up();
    end
endmodule
